/* File: eag_regs.svh */
/*
 Constants for the effective address generator: length codes, pointer
 steps, the sign bit position and the page-zero high byte.
 Assumes inclusion by bare name from the design files.
*/
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH
// Contract
// RULE_01: Accumulator mode is one byte, acts on accumulator, fetches no memory.
// RULE_02: Immediate mode takes operand from second byte, no address computation.
// RULE_03: Absolute address is second byte low, third byte high.
// RULE_04: Zero page uses second byte as low address, high byte zero.
// RULE_05: Zero page indexed adds X or Y to second byte, carry dropped.
// RULE_06: Absolute indexed adds X or Y to the 16-bit instruction base.
// RULE_07: Implied mode reads no address bytes; location comes from opcode.
// RULE_08: Relative offset added to program counter already at next instruction.
// RULE_09: Branch target spans minus 128 to plus 127 from next instruction.
// RULE_10: Indexed indirect adds second byte to X, carry dropped, zero-page pointer.
// RULE_11: Indexed indirect high byte read from next page-zero location.
// RULE_12: Indirect indexed: page-zero contents plus Y give low byte.
// RULE_13: Indirect indexed: carry plus next page-zero byte give high byte.
// RULE_14: Absolute indirect pointer and next byte load program counter.
// RULE_15: Relative offset is signed and sign-extended before the addition.
`define EAG_ZP_HIGH 8'h00
`define EAG_PTR_STEP 8'h01
`define EAG_WORD_STEP 16'h0001
`define EAG_SIGN_BIT 7
`define EAG_LEN_ONE 2'h1
`define EAG_LEN_TWO 2'h2
`define EAG_LEN_THREE 2'h3
`endif

/* File: eag_pkg.sv */
/*
 Types for the effective address generator.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package eag_pkg;
   typedef enum logic [3:0] {
      EAG_ACC, EAG_IMM, EAG_ABS, EAG_ZP, EAG_ZPX, EAG_ZPY, EAG_ABSX,
      EAG_ABSY, EAG_IMP, EAG_REL, EAG_INDX, EAG_INDY, EAG_IND
   } eag_mode_t;
   typedef enum logic [1:0] {
      EAG_IDLE, EAG_RDLO, EAG_RDHI, EAG_DONE
   } eag_state_t;
endpackage

/* File: eag_mem_if.sv */
/*
 Operand and sum channel between the address sequencer and the adder unit.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
interface eag_mem_if;
   logic [15:0] base;
   logic [7:0] index;
   logic [7:0] offs;
   logic [15:0] pc;
   logic [15:0] sum16;
   logic [7:0] sumZp;
   logic [15:0] relTarget;
   modport seq (output base, index, offs, pc, input sum16, sumZp, relTarget);
   modport adder (input base, index, offs, pc, output sum16, sumZp,
      relTarget);
endinterface

/* File: eag_adder.sv */
/*
 Combinational adders for indexed and relative address forms.
 Assumes the sequencer holds its operands stable.
*/
`timescale 1ns/1ps
`include "eag_regs.svh"
module eag_adder
(
   eag_mem_if.adder ch
);
   // ========================================
   // Indexed sums
   assign ch.sum16 = ch.base + {`EAG_ZP_HIGH, ch.index}; // RULE_06
   assign ch.sumZp = ch.base[7:0] + ch.index; // RULE_05
   // ========================================
   // Signed branch target
   assign ch.relTarget = ch.pc +
      {{8{ch.offs[`EAG_SIGN_BIT]}}, ch.offs}; // RULE_15
endmodule

/* File: eag_top.sv */
/*
 Effective address generator: forms the operand address for each memory mode
 (zero for accumulator, immediate and implied), reading page-zero or pointer bytes as needed.
 Assumes memory answers a read with rdData one cycle after memRd.
*/
`timescale 1ns/1ps
`include "eag_regs.svh"
module eag_top
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic start,
   input wire eag_pkg::eag_mode_t mode,
   input wire logic [7:0] byte2,
   input wire logic [7:0] byte3,
   input wire logic [7:0] regX,
   input wire logic [7:0] regY,
   input wire logic [15:0] pcNext,
   input wire logic [7:0] rdData,
   output logic memRd,
   output logic [15:0] memAddr,
   output logic done,
   output logic [15:0] effAddr,
   output logic [7:0] operand,
   output logic useAcc,
   output logic useImm,
   output logic loadPc,
   output logic [1:0] instLen
);
   eag_mem_if ch();
   eag_pkg::eag_state_t state_q;
   eag_pkg::eag_mode_t mode_q;
   logic [7:0] lo_q;
   logic [15:0] ptr_q;
   logic [7:0] b2_q;
   logic [7:0] b3_q;
   logic [7:0] y_q;
   logic [7:0] x_q;
   logic [15:0] pc_q;
   logic [8:0] loSum;

   eag_adder adder (.ch(ch));

   // ========================================
   // Operand routing to adders
   always_comb
   begin
      ch.pc = pc_q;
      ch.offs = b2_q;
      ch.base = {b3_q, b2_q};
      ch.index = x_q;
      case (mode_q)
         eag_pkg::EAG_ZPY, eag_pkg::EAG_ABSY: ch.index = y_q;
         eag_pkg::EAG_INDX: ch.index = x_q;
         default: ch.index = x_q;
      endcase
   end

   assign loSum = {1'b0, lo_q} + {1'b0, y_q}; // RULE_12

   function automatic logic needsPtr(input eag_pkg::eag_mode_t m);
      needsPtr = (m == eag_pkg::EAG_INDX) || (m == eag_pkg::EAG_INDY) ||
         (m == eag_pkg::EAG_IND);
   endfunction

   // ========================================
   // Sequencer
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         state_q <= eag_pkg::EAG_IDLE;
      else
      begin
         case (state_q)
            eag_pkg::EAG_IDLE:
               if (start)
                  state_q <= needsPtr(mode) ? eag_pkg::EAG_RDLO :
                     eag_pkg::EAG_DONE;
            eag_pkg::EAG_RDLO: state_q <= eag_pkg::EAG_RDHI;
            eag_pkg::EAG_RDHI: state_q <= eag_pkg::EAG_DONE;
            eag_pkg::EAG_DONE: state_q <= eag_pkg::EAG_IDLE;
            default: state_q <= eag_pkg::EAG_IDLE;
         endcase
      end
   end

   // ========================================
   // Request capture, only while idle
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         mode_q <= eag_pkg::EAG_IMP;
         b2_q <= 8'h00;
         b3_q <= 8'h00;
         x_q <= 8'h00;
         y_q <= 8'h00;
         pc_q <= 16'h0000;
      end
      else if (state_q == eag_pkg::EAG_IDLE && start)
      begin
         mode_q <= mode;
         b2_q <= byte2;
         b3_q <= byte3;
         x_q <= regX;
         y_q <= regY;
         pc_q <= pcNext; // RULE_08
      end
   end

   // ========================================
   // Pointer reads
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         memRd <= 1'b0;
         memAddr <= 16'h0000;
         ptr_q <= 16'h0000;
      end
      else
      begin
         memRd <= 1'b0;
         if (state_q == eag_pkg::EAG_IDLE && start && needsPtr(mode))
         begin
            memRd <= 1'b1;
            case (mode)
               eag_pkg::EAG_INDX:
               begin
                  memAddr <= {`EAG_ZP_HIGH,
                     byte2 + regX}; // RULE_10
                  ptr_q <= {`EAG_ZP_HIGH, byte2 + regX};
               end
               eag_pkg::EAG_INDY:
               begin
                  memAddr <= {`EAG_ZP_HIGH, byte2}; // RULE_12
                  ptr_q <= {`EAG_ZP_HIGH, byte2};
               end
               default:
               begin
                  memAddr <= {byte3, byte2}; // RULE_14
                  ptr_q <= {byte3, byte2};
               end
            endcase
         end
         else if (state_q == eag_pkg::EAG_RDLO)
         begin
            memRd <= 1'b1;
            if (mode_q == eag_pkg::EAG_IND)
               memAddr <= ptr_q + `EAG_WORD_STEP; // RULE_14
            else
               memAddr <= {`EAG_ZP_HIGH,
                  ptr_q[7:0] + `EAG_PTR_STEP}; // RULE_11
         end
      end
   end

   // ========================================
   // Low byte capture
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         lo_q <= 8'h00;
      else if (state_q == eag_pkg::EAG_RDHI)
         lo_q <= rdData;
   end

   // ========================================
   // Completion strobe
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         done <= 1'b0;
      else
         done <= (state_q == eag_pkg::EAG_DONE);
   end

   // ========================================
   // Mode flags
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         useAcc <= 1'b0;
         useImm <= 1'b0;
         loadPc <= 1'b0;
      end
      else if (state_q == eag_pkg::EAG_DONE)
      begin
         useAcc <= (mode_q == eag_pkg::EAG_ACC); // RULE_01
         useImm <= (mode_q == eag_pkg::EAG_IMM); // RULE_02
         loadPc <= (mode_q == eag_pkg::EAG_REL) ||
            (mode_q == eag_pkg::EAG_IND); // RULE_14
      end
   end

   // ========================================
   // Immediate operand
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         operand <= 8'h00;
      else if (state_q == eag_pkg::EAG_DONE)
         operand <= (mode_q == eag_pkg::EAG_IMM) ? b2_q : 8'h00; // RULE_02
   end

   // ========================================
   // Instruction length
   function automatic logic [1:0] lenOf(input eag_pkg::eag_mode_t m);
      case (m)
         eag_pkg::EAG_ACC, eag_pkg::EAG_IMP: lenOf = `EAG_LEN_ONE; // RULE_07
         eag_pkg::EAG_ABS, eag_pkg::EAG_ABSX, eag_pkg::EAG_ABSY,
            eag_pkg::EAG_IND: lenOf = `EAG_LEN_THREE;
         default: lenOf = `EAG_LEN_TWO;
      endcase
   endfunction

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         instLen <= `EAG_LEN_ONE;
      else if (state_q == eag_pkg::EAG_DONE)
         instLen <= lenOf(mode_q); // RULE_01
   end

   // ========================================
   // Effective address
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         effAddr <= 16'h0000;
      else if (state_q == eag_pkg::EAG_DONE)
      begin
         case (mode_q)
            eag_pkg::EAG_ABS: effAddr <= {b3_q, b2_q}; // RULE_03
            eag_pkg::EAG_ZP: effAddr <= {`EAG_ZP_HIGH, b2_q}; // RULE_04
            eag_pkg::EAG_ZPX, eag_pkg::EAG_ZPY:
               effAddr <= {`EAG_ZP_HIGH, ch.sumZp}; // RULE_05
            eag_pkg::EAG_ABSX, eag_pkg::EAG_ABSY:
               effAddr <= ch.sum16; // RULE_06
            eag_pkg::EAG_REL: effAddr <= ch.relTarget; // RULE_09
            eag_pkg::EAG_INDX: effAddr <= {rdData, lo_q}; // RULE_11
            eag_pkg::EAG_INDY:
               effAddr <= {rdData + {7'h00, loSum[8]},
                  loSum[7:0]}; // RULE_13
            eag_pkg::EAG_IND: effAddr <= {rdData, lo_q}; // RULE_14
            default: effAddr <= 16'h0000; // RULE_07
         endcase
      end
   end
endmodule

/* File: eag_top_assertions.sv */
/* Port checker for the effective address generator.
 Assumes one clock, requests only while idle, bind at the foot. */
`timescale 1ns/1ps
module eag_top_chk
(
   input logic clk_sys,
   input logic srst,
   input logic start,
   input eag_pkg::eag_mode_t mode,
   input logic [7:0] byte2,
   input logic [7:0] byte3,
   input logic [7:0] regX,
   input logic [7:0] regY,
   input logic [15:0] pcNext,
   input logic memRd,
   input logic [15:0] memAddr,
   input logic done,
   input logic [15:0] effAddr,
   input logic [7:0] operand,
   input logic useAcc,
   input logic useImm,
   input logic loadPc
);
   // ==========================================
   // Address forms
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   property p_acc;
      start && mode inside {eag_pkg::EAG_ACC, eag_pkg::EAG_IMP} |=> !memRd
         ##1 (done && !memRd && useAcc == ($past(mode, 2) == eag_pkg::EAG_ACC));
   endproperty
   a_acc: assert property (p_acc) else $error("no fetch");
   property p_imm;
      start && mode == eag_pkg::EAG_IMM |->
         ##2 (done && useImm && operand == $past(byte2, 2));
   endproperty
   a_imm: assert property (p_imm) else $error("immediate");
   property p_abs;
      start && mode == eag_pkg::EAG_ABS |->
         ##2 (done && effAddr == {$past(byte3, 2), $past(byte2, 2)});
   endproperty
   a_abs: assert property (p_abs) else $error("absolute");
   property p_zpx;
      start && mode == eag_pkg::EAG_ZPX |->
         ##2 (effAddr == {8'h00, 8'($past(byte2, 2) + $past(regX, 2))});
   endproperty
   a_zpx: assert property (p_zpx) else $error("zero page x");
   property p_absy;
      start && mode == eag_pkg::EAG_ABSY |-> ##2 (effAddr ==
         {$past(byte3, 2), $past(byte2, 2)} + 16'($past(regY, 2)));
   endproperty
   a_absy: assert property (p_absy) else $error("absolute y");
   property p_rel;
      start && mode == eag_pkg::EAG_REL |-> ##2 (loadPc && effAddr ==
         $past(pcNext, 2) + {{8{$past(byte2[7], 2)}}, $past(byte2, 2)});
   endproperty
   a_rel: assert property (p_rel) else $error("branch");
   property p_indx;
      start && mode == eag_pkg::EAG_INDX |-> ##1 (memRd && memAddr ==
         {8'h00, 8'($past(byte2) + $past(regX))}) ##1 (memRd && memAddr ==
         {8'h00, 8'($past(byte2, 2) + $past(regX, 2) + 8'h01)});
   endproperty
   a_indx: assert property (p_indx) else $error("ptr x");
   property p_ind;
      start && mode == eag_pkg::EAG_IND |-> ##1 (memAddr ==
         {$past(byte3), $past(byte2)}) ##1 (memAddr ==
         {$past(byte3, 2), $past(byte2, 2)} + 16'h0001) ##2 (done && loadPc);
   endproperty
   a_ind: assert property (p_ind) else $error("indirect");
endmodule
bind eag_top eag_top_chk u_chk(.clk_sys(clk_sys), .srst(srst),
   .start(start), .mode(mode), .byte2(byte2), .byte3(byte3), .regX(regX),
   .regY(regY), .pcNext(pcNext), .memRd(memRd), .memAddr(memAddr),
   .done(done), .effAddr(effAddr), .operand(operand), .useAcc(useAcc),
   .useImm(useImm), .loadPc(loadPc));

/* File: eag_top_tb.sv */
/* Self-checking bench for the effective address generator.
 Assumes the package, design and checker are compiled first. */
`timescale 1ns/1ps
module eag_top_tb;
   logic clk_sys = 1'h0, srst = 1'h1, start = 1'h0, lastRd = 1'h0;
   logic [7:0] byte2 = 8'h00, byte3 = 8'h00, regX = 8'h00, regY = 8'h00;
   logic [7:0] rdData = 8'h00, operand;
   logic [15:0] pcNext = 16'h0000, memAddr, effAddr;
   logic memRd, done, useAcc, useImm, loadPc;
   logic [1:0] instLen;
   eag_pkg::eag_mode_t mode = eag_pkg::EAG_ACC;
   int fails = 0, comparisons = 0, reads = 0;
   always #5 clk_sys = ~clk_sys;
   eag_top dut(.clk_sys(clk_sys), .srst(srst), .start(start), .mode(mode),
      .byte2(byte2), .byte3(byte3), .regX(regX), .regY(regY),
      .pcNext(pcNext), .rdData(rdData), .memRd(memRd), .memAddr(memAddr),
      .done(done), .effAddr(effAddr), .operand(operand), .useAcc(useAcc),
      .useImm(useImm), .loadPc(loadPc), .instLen(instLen));
   function automatic logic [7:0] mv(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   // ==========================================
   // Memory: answers a read, holds one cycle, then drifts
   always @(posedge clk_sys)
   begin
      lastRd <= memRd;
      if (memRd === 1'h1)
         reads++;
      rdData <= #1 memRd === 1'h1 ? mv(memAddr) : lastRd ? rdData : ~rdData;
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict;
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic run(input eag_pkg::eag_mode_t m,
      input logic [15:0] b, xy, pc, ea);
      int n;
      int w;
      logic [1:0] len;
      logic [7:0] op;
      logic [15:0] fl;
      w = m inside {eag_pkg::EAG_INDX, eag_pkg::EAG_INDY, eag_pkg::EAG_IND}
         ? 2 : 0;
      len = m inside {eag_pkg::EAG_ACC, eag_pkg::EAG_IMP} ? 2'h1 :
         m inside {eag_pkg::EAG_ABS, eag_pkg::EAG_ABSX, eag_pkg::EAG_ABSY,
         eag_pkg::EAG_IND} ? 2'h3 : 2'h2;
      op = m == eag_pkg::EAG_IMM ? b[7:0] : 8'h00;
      fl = {11'h000, m == eag_pkg::EAG_ACC, m == eag_pkg::EAG_IMM,
         m inside {eag_pkg::EAG_REL, eag_pkg::EAG_IND}, len};
      mode = m;
      {byte3, byte2} = b;
      {regX, regY} = xy;
      pcNext = pc;
      reads = 0;
      start = 1'h1;
      @(posedge clk_sys);
      #1 start = 1'h0;
      for (n = 0; n < 8 && done !== 1'h1; n++)
         @(posedge clk_sys) #1;
      chk("cycles", {8'(w + 1), 8'(w)}, {8'(n), 8'(reads)});
      chk("effAddr", ea, effAddr);
      chk("operand", {8'h00, op}, {8'h00, operand});
      chk("flags", fl, {11'h000, useAcc, useImm, loadPc, instLen});
   endtask
   // ==========================================
   // Scenarios
   task automatic t_direct;
      run(eag_pkg::EAG_ACC, 16'h3412, 16'h0102, 16'h4000, 16'h0);
      run(eag_pkg::EAG_IMP, 16'h3412, 16'h0102, 16'h4000, 16'h0);
      run(eag_pkg::EAG_IMM, 16'h00c3, 16'h0, 16'h0, 16'h0);
      run(eag_pkg::EAG_ABS, 16'h1234, 16'h0, 16'h0, 16'h1234);
      run(eag_pkg::EAG_ZP, 16'h77f0, 16'h0, 16'h0, 16'h00f0);
      run(eag_pkg::EAG_ZPX, 16'h77f0, 16'h2099, 16'h0, 16'h0010);
      run(eag_pkg::EAG_ZPY, 16'h77f0, 16'h2099, 16'h0, 16'h0089);
      run(eag_pkg::EAG_ABSX, 16'h12f0, 16'h2000, 16'h0, 16'h1310);
      run(eag_pkg::EAG_ABSY, 16'hffff, 16'h5501, 16'h0, 16'h0);
   endtask
   task automatic t_branch;
      run(eag_pkg::EAG_REL, 16'h007f, 16'h0, 16'h1000, 16'h107f);
      run(eag_pkg::EAG_REL, 16'h0080, 16'h0, 16'h1000, 16'h0f80);
      run(eag_pkg::EAG_REL, 16'h0006, 16'h0, 16'h10fe, 16'h1104);
   endtask
   task automatic t_ptr;
      run(eag_pkg::EAG_INDX, 16'h00f0, 16'h0f00, 16'h0,
         {mv(16'h0), mv(16'h00ff)});
      run(eag_pkg::EAG_INDY, 16'h00ff, 16'h00ff, 16'h0,
         {mv(16'h0), mv(16'h00ff)} + 16'h00ff);
      run(eag_pkg::EAG_IND, 16'h12ff, 16'h0, 16'h0,
         {mv(16'h1300), mv(16'h12ff)});
   endtask
   initial
   begin
      repeat (2) @(posedge clk_sys);
      #1 srst = 1'h0;
      t_direct;
      t_branch;
      t_ptr;
      give_verdict;
   end
   initial
   begin
      #20000 fails++;
      give_verdict;
   end
endmodule
